// ==== rtl/pgp_defines.vh ====
// Purpose: constants for the pin control block
// Assumes: 8-bit register port, addresses as printed
// Notes: included by the pin and top design files; the synchroniser does not include it
// Contract
// RL1: Read-only input levels, bit2 irq pin, bits1:0 pins
// RL2: Output data bits 3..0, reset zero
// RL3: Pin0 function field bits 7:5 selects mode
// RL4: Pin0 code 4 copies irq pin input
// RL5: Pin1 code 4 copies pin0 input
// RL6: Irq pin codes: irq, sequencer, plain, loop
// RL7: Polarity bit 4, one means active low
// RL8: Pull-down bit 3, pull-up bit 2
// RL9: Bit 1 selects push-pull over open drain
// RL10: Bit 0 makes the pin an output
// RL11: Bit 6 inverts data line output
// RL12: Bits 1:0 select buck1 alternate source
// RL13: Bits 3:2 select buck2 alternate source
// RL14: Bits 5:4 override buck3 with buck2 alternate
// RL15: Source codes: never, pin0, pin1, irq pin
// RL16: Bit 7: both pins choose buck2 target
// RL17: Power-up slots held for all four outputs
// RL18: Power-down slots held for all four outputs
// RL19: Pin event masks suppress interrupt assertion
// RL20: Active-low outputs drive inverted value
`ifndef PGP_DEFINES_VH
`define PGP_DEFINES_VH
`define PGP_A_IN 8'h17
`define PGP_A_OUT 8'h18
`define PGP_A_CFG0 8'h19
`define PGP_A_CFG1 8'h1a
`define PGP_A_CFGI 8'h1b
`define PGP_A_VSEL 8'h1c
`define PGP_A_UP 8'h1d
`define PGP_A_DN 8'h1e
`define PGP_A_SDAS 8'h1f
`define PGP_A_IRQS 8'h20
`define PGP_RST 8'h00
`define PGP_F_HI 7
`define PGP_F_LO 5
`define PGP_B_POL 4
`define PGP_B_PD 3
`define PGP_B_PU 2
`define PGP_B_PP 1
`define PGP_B_OE 0
`define PGP_B_SDAPOL 6
`define PGP_B_TWO 7
`define PGP_FN_PLAIN 3'h0
`define PGP_FN_SEQ 3'h1
`define PGP_FN_EXTI 3'h2
`define PGP_FN_EXTPD 3'h3
`define PGP_FN_LOOP 3'h4
`define PGP_FN_MUTE 3'h5
`define PGP_FI_IRQ 3'h0
`define PGP_FI_PLAIN 3'h2
`define PGP_SRC_NONE 2'h0
`define PGP_SRC_P0 2'h1
`define PGP_SRC_P1 2'h2
`define PGP_SRC_IRQ 2'h3
`define PGP_T_NORM 2'h0
`define PGP_T_ALT2 2'h1
`define PGP_T_ALT1 2'h2
`define PGP_T_ALT3 2'h3
`endif

// ==== rtl/pgp_pin.v ====
// Purpose: drive logic of one configurable pin
// Assumes: cfg is the pin's configuration byte
// Notes: open drain only ever pulls low
`timescale 1ns/10ps
`include "pgp_defines.vh"
module pgp_pin (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] cfg,
    input wire value,
    input wire drive,
    output reg pin_o,
    output reg pin_oe_n,
    output reg pull_up,
    output reg pull_down
);
    wire lvl;
    assign lvl = value ^ cfg[`PGP_B_POL]; // RL7 RL20
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_o <= 1'b0;
            pin_oe_n <= 1'b1;
            pull_up <= 1'b0;
            pull_down <= 1'b0;
        end else begin
            pull_down <= cfg[`PGP_B_PD]; // RL8
            pull_up <= cfg[`PGP_B_PU]; // RL8
            pin_o <= lvl;
            // Open drain releases for a high level
            pin_oe_n <= ~(drive & (cfg[`PGP_B_PP] | ~lvl)); // RL9 RL10
        end
    end
endmodule // pgp_pin

// ==== rtl/pgp_sync.v ====
// Purpose: two-stage synchroniser for pin levels
// Assumes: single clock, synchronous reset
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module pgp_sync (
    input wire clk,
    input wire sys_rst,
    input wire din,
    output reg dout
);
    reg meta_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // pgp_sync

// ==== rtl/pgp_top.v ====
// Purpose: pin control block of the power manager
// Assumes: registers reached by an 8-bit byte port
// Notes: sequencer, bucks and irq masking lie outside
`timescale 1ns/10ps
`include "pgp_defines.vh"
module pgp_top (
    input wire clk,
    input wire sys_rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire pin0_i,
    input wire pin1_i,
    input wire irq_pin_i,
    output wire pin0_o,
    output wire pin0_oe_n,
    output wire pin0_pu,
    output wire pin0_pd,
    output wire pin1_o,
    output wire pin1_oe_n,
    output wire pin1_pu,
    output wire pin1_pd,
    output wire irq_pin_o,
    output wire irq_pin_oe_n,
    output wire irq_pin_pu,
    output wire irq_pin_pd,
    input wire sda_gpo_en,
    output reg sda_o,
    input wire [1:0] seq_drive,
    input wire seq_irq_drive,
    input wire seq_sda_drive,
    input wire irq_request,
    input wire [1:0] pin0_event_mask,
    output reg [1:0] pin_event,
    output reg [1:0] ext_power_down,
    output reg mute_request,
    output reg [1:0] buck1_target_sel,
    output reg [1:0] buck2_target_sel,
    output reg [1:0] buck3_target_sel,
    output reg [7:0] up_slots_r,
    output reg [7:0] dn_slots_r,
    output reg [7:0] sda_slots_r,
    output reg [7:0] irq_slots_r
);
    // *****************************
    // Registers
    // *****************************
    reg [3:0] out_r;
    reg [7:0] cfg0_r;
    reg [7:0] cfg1_r;
    reg [7:0] cfgi_r;
    reg [7:0] vsel_r;
    wire p0_s;
    wire p1_s;
    wire pi_s;
    wire [2:0] in_lvl;
    wire [2:0] pin0_function;
    wire [2:0] pin1_function;
    wire [2:0] irq_pin_function;
    assign pin0_function = cfg0_r[`PGP_F_HI:`PGP_F_LO];
    assign pin1_function = cfg1_r[`PGP_F_HI:`PGP_F_LO];
    assign irq_pin_function = cfgi_r[`PGP_F_HI:`PGP_F_LO];

    pgp_sync u_s0 (.clk(clk), .sys_rst(sys_rst), .din(pin0_i), .dout(p0_s));
    pgp_sync u_s1 (.clk(clk), .sys_rst(sys_rst), .din(pin1_i), .dout(p1_s));
    pgp_sync u_si (.clk(clk), .sys_rst(sys_rst), .din(irq_pin_i), .dout(pi_s));
    assign in_lvl = {pi_s, p1_s, p0_s}; // RL1

    always @(posedge clk) begin
        if (sys_rst) begin
            out_r <= 4'h0; // RL2
            cfg0_r <= `PGP_RST;
            cfg1_r <= `PGP_RST;
            cfgi_r <= `PGP_RST;
            vsel_r <= `PGP_RST;
            up_slots_r <= `PGP_RST; // RL17
            dn_slots_r <= `PGP_RST; // RL18
            sda_slots_r <= `PGP_RST;
            irq_slots_r <= `PGP_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `PGP_A_OUT: out_r <= reg_wdata[3:0]; // RL2
                `PGP_A_CFG0: cfg0_r <= reg_wdata; // RL3
                `PGP_A_CFG1: cfg1_r <= reg_wdata; // RL5
                `PGP_A_CFGI: cfgi_r <= reg_wdata; // RL6
                `PGP_A_VSEL: vsel_r <= reg_wdata;
                `PGP_A_UP: up_slots_r <= reg_wdata; // RL17
                `PGP_A_DN: dn_slots_r <= reg_wdata; // RL18
                `PGP_A_SDAS: sda_slots_r <= reg_wdata; // RL17 RL18
                `PGP_A_IRQS: irq_slots_r <= reg_wdata; // RL17 RL18
                default: ;
            endcase
        end
    end

    // Unmapped reads return zero
    always @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PGP_A_IN: reg_rdata <= {5'h00, in_lvl}; // RL1
                `PGP_A_OUT: reg_rdata <= {4'h0, out_r};
                `PGP_A_CFG0: reg_rdata <= cfg0_r;
                `PGP_A_CFG1: reg_rdata <= cfg1_r;
                `PGP_A_CFGI: reg_rdata <= cfgi_r;
                `PGP_A_VSEL: reg_rdata <= vsel_r;
                `PGP_A_UP: reg_rdata <= up_slots_r;
                `PGP_A_DN: reg_rdata <= dn_slots_r;
                `PGP_A_SDAS: reg_rdata <= sda_slots_r;
                `PGP_A_IRQS: reg_rdata <= irq_slots_r;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // *****************************
    // Function selection
    // *****************************
    reg v0, d0, v1, d1, vi, di;
    always @* begin
        v0 = out_r[0];
        d0 = cfg0_r[`PGP_B_OE]; // RL10
        case (pin0_function)
            `PGP_FN_SEQ: begin v0 = seq_drive[0]; d0 = 1'b1; end // RL3
            `PGP_FN_LOOP: begin v0 = pi_s; d0 = 1'b1; end // RL4
            `PGP_FN_EXTI, `PGP_FN_EXTPD, `PGP_FN_MUTE: d0 = 1'b0; // RL3
            default: ;
        endcase
        v1 = out_r[1];
        d1 = cfg1_r[`PGP_B_OE];
        case (pin1_function)
            `PGP_FN_SEQ: begin v1 = seq_drive[1]; d1 = 1'b1; end
            `PGP_FN_LOOP: begin v1 = p0_s; d1 = 1'b1; end // RL5
            `PGP_FN_EXTI, `PGP_FN_EXTPD, `PGP_FN_MUTE: d1 = 1'b0; // RL5
            default: ;
        endcase
        vi = out_r[2];
        di = 1'b0;
        case (irq_pin_function)
            `PGP_FI_IRQ: begin vi = irq_request; di = 1'b1; end // RL6
            `PGP_FN_SEQ: begin vi = seq_irq_drive; di = 1'b1; end // RL6
            `PGP_FI_PLAIN: di = cfgi_r[`PGP_B_OE]; // RL6
            `PGP_FN_LOOP: begin vi = p1_s; di = 1'b1; end // RL6
            default: ;
        endcase
    end

    pgp_pin u_p0 (.clk(clk), .sys_rst(sys_rst), .cfg(cfg0_r), .value(v0), .drive(d0),
        .pin_o(pin0_o), .pin_oe_n(pin0_oe_n), .pull_up(pin0_pu), .pull_down(pin0_pd));
    pgp_pin u_p1 (.clk(clk), .sys_rst(sys_rst), .cfg(cfg1_r), .value(v1), .drive(d1),
        .pin_o(pin1_o), .pin_oe_n(pin1_oe_n), .pull_up(pin1_pu), .pull_down(pin1_pd));
    pgp_pin u_pi (.clk(clk), .sys_rst(sys_rst), .cfg(cfgi_r), .value(vi), .drive(di),
        .pin_o(irq_pin_o), .pin_oe_n(irq_pin_oe_n), .pull_up(irq_pin_pu),
        .pull_down(irq_pin_pd));

    // *****************************
    // Inputs, events, buck select
    // *****************************
    // Active-low inputs are normalised for events, power-down and mute; buck select uses raw levels
    wire a0, a1;
    assign a0 = p0_s ^ cfg0_r[`PGP_B_POL]; // RL7
    assign a1 = p1_s ^ cfg1_r[`PGP_B_POL]; // RL7
    wire ai;
    assign ai = pi_s ^ cfgi_r[`PGP_B_POL]; // RL7
    wire [3:0] srcs;
    assign srcs = {pi_s, p1_s, p0_s, 1'b0}; // RL15
    wire [1:0] s1, s2, s3;
    assign s1 = vsel_r[1:0];
    assign s2 = vsel_r[3:2];
    assign s3 = vsel_r[5:4];
    wire sda_val;
    assign sda_val = sda_gpo_en ? seq_sda_drive : out_r[3];

    always @(posedge clk) begin
        if (sys_rst) begin
            sda_o <= 1'b0;
            pin_event <= 2'h0;
            ext_power_down <= 2'h0;
            mute_request <= 1'b0;
            buck1_target_sel <= `PGP_T_NORM;
            buck2_target_sel <= `PGP_T_NORM;
            buck3_target_sel <= `PGP_T_NORM;
        end else begin
            sda_o <= sda_val ^ vsel_r[`PGP_B_SDAPOL]; // RL11
            pin_event[0] <= a0 & (pin0_function == `PGP_FN_EXTI) & ~pin0_event_mask[0]; // RL19
            pin_event[1] <= a1 & (pin1_function == `PGP_FN_EXTI) & ~pin0_event_mask[1]; // RL19
            ext_power_down <= {a1 & (pin1_function == `PGP_FN_EXTPD),
                a0 & (pin0_function == `PGP_FN_EXTPD)};
            mute_request <= (a0 & (pin0_function == `PGP_FN_MUTE))
                | (a1 & (pin1_function == `PGP_FN_MUTE))
                | (ai & (irq_pin_function == `PGP_FN_MUTE)); // RL6
            if (vsel_r[`PGP_B_TWO]) begin
                buck1_target_sel <= `PGP_T_NORM; // RL16
                buck3_target_sel <= `PGP_T_NORM; // RL16
                case ({p1_s, p0_s})
                    2'b01: buck2_target_sel <= `PGP_T_ALT2;
                    2'b10: buck2_target_sel <= `PGP_T_ALT1;
                    2'b11: buck2_target_sel <= `PGP_T_ALT3;
                    default: buck2_target_sel <= `PGP_T_NORM;
                endcase
            end else begin
                buck1_target_sel <= srcs[s1] ? `PGP_T_ALT1 : `PGP_T_NORM; // RL12
                buck2_target_sel <= srcs[s2] ? `PGP_T_ALT2 : `PGP_T_NORM; // RL13
                buck3_target_sel <= srcs[s3] ? `PGP_T_ALT2 : `PGP_T_NORM; // RL14
            end
        end
    end
endmodule // pgp_top

// ==== tb/pgp_board.sv ====
// Purpose: board side of the three pins
// Assumes: device drive wins over the board
// Notes: a released pin with no board drive and no pull keeps toggling
`timescale 1ns/10ps
module pgp_board (
    input wire clk,
    input wire [2:0] dev_o,
    input wire [2:0] dev_oe_n,
    input wire [2:0] pu,
    input wire [2:0] pd,
    input wire [2:0] ext_en,
    input wire [2:0] ext_lvl,
    output logic [2:0] lvl
);
    // ****************************************
    // Wire level resolution
    // ****************************************
    logic [2:0] last = 3'h0;
    always @(posedge clk) last <= lvl;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (!dev_oe_n[i]) lvl[i] = dev_o[i];
            else if (ext_en[i]) lvl[i] = ext_lvl[i];
            else if (pu[i] | pd[i]) lvl[i] = pu[i];
            else lvl[i] = ~last[i];
        end
    end
endmodule // pgp_board

// ==== tb/pgp_props.sv ====
// Purpose: port checks for the pin control block
// Assumes: one clock, synchronous reset active high
// Notes: shadows a few configuration bytes from the writes
`timescale 1ns/10ps
module pgp_props (
    input wire clk,
    input wire sys_rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire irq_pin_i,
    input wire pin0_o,
    input wire pin0_pu,
    input wire pin1_oe_n,
    input wire [1:0] pin0_event_mask,
    input wire [1:0] pin_event,
    input wire [1:0] buck1_target_sel,
    input wire [7:0] up_slots_r
);
    // ****************************************
    // Shadow registers and checks
    // ****************************************
    reg [7:0] cfg0_h;
    reg [7:0] cfg1_h;
    reg [7:0] vsel_h;
    always @(posedge clk) begin
        if (sys_rst) begin
            cfg0_h <= 8'h00;
            cfg1_h <= 8'h00;
            vsel_h <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == 8'h19) cfg0_h <= reg_wdata;
            if (reg_addr == 8'h1a) cfg1_h <= reg_wdata;
            if (reg_addr == 8'h1c) vsel_h <= reg_wdata;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_in_read: assert property (reg_rd && reg_addr == 8'h17 |=> reg_rdata[7:3] == 5'h00)
        else $error("input byte has upper bits set");
    a_out_read: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata[7:4] == 4'h0)
        else $error("output byte has upper bits set");
    a_pullup_copy: assert property ($stable(cfg0_h) [*4] |-> pin0_pu == cfg0_h[2])
        else $error("pull-up differs from its bit");
    a_up_slots: assert property (reg_wr && reg_addr == 8'h1d |-> ##2 up_slots_r == $past(reg_wdata, 2))
        else $error("power-up slots not stored");
    a_loop_copy: assert property ((cfg0_h[7:5] == 3'h4 && cfg0_h[1] && !cfg0_h[4] &&
        $stable(cfg0_h) && $stable(irq_pin_i)) [*5] |-> pin0_o == irq_pin_i)
        else $error("loop output does not follow input");
    a_input_release: assert property (($stable(cfg1_h) && cfg1_h[7:5] == 3'h0 &&
        !cfg1_h[0]) [*3] |-> pin1_oe_n)
        else $error("input pin is driven");
    a_event_masked: assert property (pin0_event_mask[0] [*2] |-> !pin_event[0])
        else $error("masked event raised");
    a_buck_never: assert property (($stable(vsel_h) && vsel_h[1:0] == 2'h0 &&
        !vsel_h[7]) [*3] |-> buck1_target_sel == 2'h0)
        else $error("buck target overridden with no source");
endmodule // pgp_props

bind pgp_top pgp_props u_props (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .irq_pin_i, .pin0_o, .pin0_pu, .pin1_oe_n, .pin0_event_mask, .pin_event,
    .buck1_target_sel, .up_slots_r);

// ==== tb/pmic_gpio_pin_control_test.sv ====
// Purpose: self-checking bench for the pin control block
// Assumes: board model drives all three pin inputs
// Notes: waits of six cycles cover the sync and output stages
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module pmic_gpio_pin_control_test;
    // ****************************************
    // Signals, design and board
    // ****************************************
    logic clk, sys_rst = 1, reg_wr = 0, reg_rd = 0, sda_gpo_en = 0;
    logic seq_irq_drive = 0, seq_sda_drive = 0, irq_request = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0;
    logic [1:0] seq_drive = 0, pin0_event_mask = 0;
    logic [2:0] ext_en = 3'h7, ext_lvl = 3'h0;
    wire [7:0] reg_rdata, up_slots_r, dn_slots_r, sda_slots_r, irq_slots_r;
    wire pin0_i, pin1_i, irq_pin_i, pin0_o, pin0_oe_n, pin0_pu, pin0_pd, pin1_o, pin1_oe_n;
    wire pin1_pu, pin1_pd, irq_pin_o, irq_pin_oe_n, irq_pin_pu, irq_pin_pd, sda_o, mute_request;
    wire [1:0] pin_event, ext_power_down, buck1_target_sel, buck2_target_sel, buck3_target_sel;
    int n_fail = 0, n_tests = 0;
    pgp_top uut (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pin0_i,
        .pin1_i, .irq_pin_i, .pin0_o, .pin0_oe_n, .pin0_pu, .pin0_pd, .pin1_o, .pin1_oe_n, .pin1_pu,
        .pin1_pd, .irq_pin_o, .irq_pin_oe_n, .irq_pin_pu, .irq_pin_pd, .sda_gpo_en, .sda_o,
        .seq_drive, .seq_irq_drive, .seq_sda_drive, .irq_request, .pin0_event_mask, .pin_event,
        .ext_power_down, .mute_request, .buck1_target_sel, .buck2_target_sel, .buck3_target_sel,
        .up_slots_r, .dn_slots_r, .sda_slots_r, .irq_slots_r);
    pgp_board brd (.clk, .dev_o({irq_pin_o, pin1_o, pin0_o}),
        .dev_oe_n({irq_pin_oe_n, pin1_oe_n, pin0_oe_n}), .pu({irq_pin_pu, pin1_pu, pin0_pu}),
        .pd({irq_pin_pd, pin1_pd, pin0_pd}), .ext_en, .ext_lvl, .lvl({irq_pin_i, pin1_i, pin0_i}));
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Bus tasks and scenarios
    // ****************************************
    task wr(input [7:0] a, input [7:0] d);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk) reg_wr <= 0;
        @(posedge clk);
    endtask
    task rd(input [7:0] a, input [7:0] e);
        reg_rd <= 1; reg_addr <= a;
        @(posedge clk) reg_rd <= 0;
        @(posedge clk) `CHK("rdata", e, reg_rdata)
    endtask
    task st;
        repeat (6) @(posedge clk);
    endtask
    task t_regs;
        for (int a = 8'h17; a < 8'h22; a++) rd(a[7:0], 8'h00);
        `CHK("oe_n", 3'h3, {irq_pin_oe_n, pin1_oe_n, pin0_oe_n})
        wr(8'h18, 8'hff); rd(8'h18, 8'h0f);
        wr(8'h17, 8'hff); rd(8'h17, 8'h00);
        for (int i = 0; i < 4; i++) wr(8'h1d + i[7:0], 8'h5a + i[7:0]);
        `CHK("slots", 32'h5a5b5c5d, {up_slots_r, dn_slots_r, sda_slots_r, irq_slots_r})
        rd(8'h1e, 8'h5b);
        wr(8'h1b, 8'h40); wr(8'h18, 8'h00); ext_lvl <= 3'b101; st; rd(8'h17, 8'h05);
    endtask
    task t_pins;
        wr(8'h19, 8'h03); wr(8'h18, 8'h01); st; `CHK("pin0", 2'b10, {pin0_o, pin0_oe_n})
        wr(8'h19, 8'h13); st; `CHK("pin0", 2'b00, {pin0_o, pin0_oe_n})
        wr(8'h19, 8'h01); st; `CHK("pin0 oe_n", 1'b1, pin0_oe_n)
        wr(8'h19, 8'h0c); st; `CHK("pulls", 3'h7, {pin0_oe_n, pin0_pu, pin0_pd})
        wr(8'h1a, 8'h23); seq_drive <= 2'b10; st; `CHK("seq", 2'b10, {pin1_o, pin1_oe_n})
        wr(8'h1b, 8'h40); wr(8'h19, 8'h83); wr(8'h1a, 8'h93);
        for (int v = 0; v < 2; v++) begin
            ext_lvl <= {v[0], 2'b00}; st; st;
            `CHK("loop", {v[0], ~v[0]}, {pin0_o, pin1_o})
        end
        wr(8'h1b, 8'h03); irq_request <= 1; st; `CHK("irq out", 1'b1, irq_pin_o)
        wr(8'h1b, 8'h63); st; `CHK("irq oe_n", 1'b1, irq_pin_oe_n)
        wr(8'h1b, 8'h00); wr(8'h1a, 8'h00); wr(8'h19, 8'h40); ext_lvl <= 3'b001; st;
        `CHK("event", 2'b01, pin_event)
        pin0_event_mask <= 2'b01; st; `CHK("event", 2'b00, pin_event)
        wr(8'h19, 8'h60); st; `CHK("power down", 2'b01, ext_power_down)
        wr(8'h19, 8'ha0); st; `CHK("mute", 1'b1, mute_request)
        wr(8'h19, 8'h00); wr(8'h1b, 8'ha0); ext_lvl <= 3'b100; st;
        `CHK("irq mute", 1'b1, mute_request)
    endtask
    task t_buck;
        wr(8'h19, 8'h00);
        for (int s = 1; s < 4; s++) begin
            wr(8'h1c, {2'b00, s[1:0], s[1:0], s[1:0]}); ext_lvl <= 3'b000; st;
            `CHK("buck", 6'h00, {buck1_target_sel, buck2_target_sel, buck3_target_sel})
            ext_lvl <= 3'b001 << (s - 1); st;
            `CHK("buck", 6'b100101, {buck1_target_sel, buck2_target_sel, buck3_target_sel})
        end
        wr(8'h1c, 8'h80);
        for (int v = 0; v < 4; v++) begin
            ext_lvl <= {1'b0, v[1:0]}; st; `CHK("buck2", v[1:0], buck2_target_sel)
        end
        wr(8'h18, 8'h08); st; `CHK("sda", 1'b1, sda_o)
        wr(8'h1c, 8'h40); st; `CHK("sda", 1'b0, sda_o)
        sda_gpo_en <= 1; seq_sda_drive <= 1; seq_irq_drive <= 1; st; `CHK("sda", 1'b0, sda_o)
    endtask
    task give_verdict;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk);
        t_regs; t_pins; t_buck;
        give_verdict;
    end
endmodule // pmic_gpio_pin_control_test
